// *** card_host_pkg.sv ***
// Shared types and constants for the card select and byte-lane host port
package card_host_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int DATA_W        = 16;
    localparam int ADDR_W        = 11;
    localparam int INDEX_W       = 3;
    localparam int BYTE_ADDR_BIT = 0;
    localparam int FIFO_DEPTH    = 8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int ACCESS_NS     = 80;
    localparam int RECOVER_NS    = 30;
    localparam int ACCESS_CYC    =
        (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVER_CYC   =
        (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 4;

    // ------------------------------------------------------------------
    // Modes, operations, carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MEMORY = 2'b00,
        MODE_IO     = 2'b01,
        MODE_ATA    = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        OP_BYTE_LOW  = 2'b00,
        OP_BYTE_HIGH = 2'b01,
        OP_WORD      = 2'b10,
        OP_DMA_WORD  = 2'b11
    } op_t;

    typedef struct packed {
        mode_t mode;
        logic  master;
    } cfg_t;

    typedef struct packed {
        op_t               op;
        logic              write;
        logic              upper_addr;
        logic [ADDR_W-1:0] addr;
    } req_t;

    typedef struct packed {
        op_t               op;
        logic [DATA_W-1:0] data;
    } rsp_t;

    typedef struct packed {
        logic              low_n;
        logic              high_n;
        logic              tf_n;
        logic              aux_n;
        logic              dack_n;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        oe;
        logic [DATA_W-1:0] dout;
    } pins_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam pins_t PINS_IDLE = '{
        low_n: 1'b1, high_n: 1'b1, tf_n: 1'b1, aux_n: 1'b1,
        dack_n: 1'b1, addr: 11'h000, oe: 2'h0, dout: 16'h0000};
    localparam req_t  REQ_RESET  = '{OP_BYTE_LOW, 1'b0, 1'b0, 11'h000};
    localparam rsp_t  RSP_RESET  = '{OP_BYTE_LOW, 16'h0000};
    localparam logic  ROLE_RESET_OE = 1'b1;

endpackage : card_host_pkg

// *** word_fifo.sv ***
// Show-ahead FIFO with valid and ready on both sides
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wptr;
    logic [PW:0]      rptr;
    logic [PW:0]      next_wptr;
    logic [PW:0]      next_rptr;
    logic             next_in_ready;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (wptr != rptr);
    assign out_data  = mem[rptr[PW-1:0]];

    always_comb begin
        next_wptr     = push ? wptr + 1'b1 : wptr;
        next_rptr     = pop ? rptr + 1'b1 : rptr;
        // Full when pointers differ only in the wrap bit
        next_in_ready = !((next_wptr[PW] != next_rptr[PW]) &&
                          (next_wptr[PW-1:0] == next_rptr[PW-1:0]));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr     <= '0;
            rptr     <= '0;
            in_ready <= 1'b1;
        end else begin
            wptr     <= next_wptr;
            rptr     <= next_rptr;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr[PW-1:0]] <= in_data;
        end
    end

endmodule : word_fifo

// *** card_host_port.sv ***
// Host-side card select, byte-lane and data-bus driver
// What this block does
// - ATA mode drives index lines, upper address zero
// - Selects negated and word wide during DMA acknowledge
// - Memory/IO modes: drive role pin from upper address
// - Data lines are two-way, host drives on writes
// - Even byte on low lanes, odd on low or high lanes
// - ATA register accesses are bytes on low lanes
// - ATA data transfers are full sixteen-bit words
module card_host_port
    import card_host_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Static configuration
    input  wire card_host_pkg::cfg_t           cfg,
    // Access requests
    input  wire logic                          req_valid,
    input  wire card_host_pkg::req_t           req,
    output logic                               req_ready,
    // Write data stream
    input  wire logic                          wr_valid,
    input  wire logic [card_host_pkg::DATA_W-1:0] wr_data,
    output logic                               wr_ready,
    // Access completions
    output logic                               rsp_valid,
    output card_host_pkg::rsp_t                rsp,
    // Card selects
    output logic                               low_lane_enable_n,
    output logic                               high_lane_enable_n,
    output logic                               task_file_select_n,
    output logic                               aux_register_select_n,
    output logic                               dma_acknowledge_n,
    output logic [card_host_pkg::ADDR_W-1:0]   card_address,
    // Drive role pin
    output logic                               drive_role_select_out,
    output logic                               drive_role_select_oe,
    // Card data lines
    output logic [card_host_pkg::DATA_W-1:0]   card_data_lines_out,
    output logic [1:0]                         card_data_lines_oe,
    input  wire logic [card_host_pkg::DATA_W-1:0] card_data_lines_in
);
    import card_host_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACTIVE  = 2'b01,
        ST_RECOVER = 2'b10
    } state_t;

    state_t            state;
    state_t            next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    req_t              cur;
    req_t              next_cur;
    pins_t             pins;
    pins_t             next_pins;
    logic              next_req_ready;
    rsp_t              next_rsp;
    logic              next_rsp_valid;
    logic              next_role_out;
    logic              next_role_oe;
    logic [DATA_W-1:0] din_meta;
    logic [DATA_W-1:0] din_sync;
    logic              wq_valid;
    logic [DATA_W-1:0] wq_data;
    logic              wq_pop;
    logic              accept;

    // ------------------------------------------------------------------
    // Write data buffer
    // ------------------------------------------------------------------
    word_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (wr_valid),
        .in_data   (wr_data),
        .in_ready  (wr_ready),
        .out_valid (wq_valid),
        .out_data  (wq_data),
        .out_ready (wq_pop)
    );

    // ------------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------------
    function automatic pins_t decode(mode_t m, req_t r,
                                     logic [DATA_W-1:0] wd);
        pins_t p;
        p = PINS_IDLE;
        if (r.op == OP_DMA_WORD) begin
            // Both selects stay high, whole word moves
            p.dack_n = 1'b0;
            p.oe     = 2'b11;
            p.dout   = wd;
        end else if (m == MODE_ATA) begin
            p.addr = {8'h00, r.addr[INDEX_W-1:0]};
            unique case (r.op)
                OP_BYTE_HIGH: begin
                    p.aux_n = 1'b0;
                    p.oe    = 2'b01;
                    p.dout  = {8'h00, wd[7:0]};
                end
                OP_WORD: begin
                    p.tf_n = 1'b0;
                    p.oe   = 2'b11;
                    p.dout = wd;
                end
                default: begin
                    p.tf_n = 1'b0;
                    p.oe   = 2'b01;
                    p.dout = {8'h00, wd[7:0]};
                end
            endcase
        end else begin
            p.addr = r.addr;
            unique case (r.op)
                OP_BYTE_HIGH: begin
                    p.high_n = 1'b0;
                    p.oe     = 2'b10;
                    p.dout   = {wd[7:0], 8'h00};
                end
                OP_WORD: begin
                    p.low_n  = 1'b0;
                    p.high_n = 1'b0;
                    p.oe     = 2'b11;
                    p.dout   = wd;
                end
                default: begin
                    // Even or odd byte by address bit zero
                    p.low_n = 1'b0;
                    p.oe    = 2'b01;
                    p.dout  = {8'h00, wd[7:0]};
                end
            endcase
        end
        if (!r.write) begin
            p.oe = 2'b00;
        end
        return p;
    endfunction : decode

    // Read byte lands in the low byte of the answer
    function automatic logic [DATA_W-1:0] gather(mode_t m, op_t op,
                                               logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = d;
        if (op == OP_BYTE_HIGH && m != MODE_ATA) begin
            v = {8'h00, d[15:8]};
        end else if (op != OP_WORD && op != OP_DMA_WORD) begin
            v = {8'h00, d[7:0]};
        end
        return v;
    endfunction : gather

    // ------------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_meta <= '0;
            din_sync <= '0;
        end else begin
            din_meta <= card_data_lines_in;
            din_sync <= din_meta;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    // A write waits for its data word so the pins never show stale data
    assign accept = req_valid && req_ready && (!req.write || wq_valid);
    assign wq_pop = (state == ST_ACTIVE) && (cnt == '0) && cur.write;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_cur       = cur;
        next_pins      = pins;
        next_rsp       = rsp;
        next_rsp_valid = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_cur   = req;
                    next_pins  = decode(cfg.mode, req, wq_data);
                    next_cnt   = CNT_W'(ACCESS_CYC - 1);
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (cnt == '0) begin
                    // Access long enough to cover the input sync lag
                    next_rsp.op    = cur.op;
                    next_rsp.data  = cur.write ? pins.dout
                                   : gather(cfg.mode, cur.op, din_sync);
                    next_rsp_valid = 1'b1;
                    next_pins      = PINS_IDLE;
                    next_cnt       = CNT_W'(RECOVER_CYC - 1);
                    next_state     = ST_RECOVER;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            ST_RECOVER: begin
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_pins  = PINS_IDLE;
            end
        endcase
        next_req_ready = (next_state == ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Drive role pin
    // ------------------------------------------------------------------
    always_comb begin
        if (cfg.mode == MODE_ATA) begin
            // Ground for master, release to card pull-up for slave
            next_role_out = 1'b0;
            next_role_oe  = cfg.master;
        end else begin
            next_role_out = cur.upper_addr;
            next_role_oe  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state                 <= ST_IDLE;
            cnt                   <= '0;
            cur                   <= REQ_RESET;
            pins                  <= PINS_IDLE;
            req_ready             <= 1'b0;
            rsp                   <= RSP_RESET;
            rsp_valid             <= 1'b0;
            drive_role_select_out <= 1'b0;
            drive_role_select_oe  <= ROLE_RESET_OE;
        end else begin
            state                 <= next_state;
            cnt                   <= next_cnt;
            cur                   <= next_cur;
            pins                  <= next_pins;
            req_ready             <= next_req_ready;
            rsp                   <= next_rsp;
            rsp_valid             <= next_rsp_valid;
            drive_role_select_out <= next_role_out;
            drive_role_select_oe  <= next_role_oe;
        end
    end

    assign low_lane_enable_n     = pins.low_n;
    assign high_lane_enable_n    = pins.high_n;
    assign task_file_select_n    = pins.tf_n;
    assign aux_register_select_n = pins.aux_n;
    assign dma_acknowledge_n     = pins.dack_n;
    assign card_address          = pins.addr;
    assign card_data_lines_out   = pins.dout;
    assign card_data_lines_oe    = pins.oe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_dma_selects;
        @(posedge clk) disable iff (!rstn)
        !dma_acknowledge_n |-> task_file_select_n && aux_register_select_n
            && (card_data_lines_oe == 2'b11 || !cur.write);
    endproperty
    a_dma_selects: assert property (p_dma_selects)
        else $error("register select asserted during DMA acknowledge");

    property p_ata_index;
        @(posedge clk) disable iff (!rstn)
        (!task_file_select_n || !aux_register_select_n)
            |-> card_address[ADDR_W-1:INDEX_W] == '0;
    endproperty
    a_ata_index: assert property (p_ata_index)
        else $error("upper address not grounded in ATA access");

    property p_tf_byte;
        @(posedge clk) disable iff (!rstn)
        (!task_file_select_n && cur.write && cur.op == OP_BYTE_LOW)
            |-> card_data_lines_oe == 2'b01;
    endproperty
    a_tf_byte: assert property (p_tf_byte)
        else $error("task-file byte not on low lanes only");

    property p_aux_select;
        @(posedge clk) disable iff (!rstn)
        !aux_register_select_n |-> task_file_select_n
            && low_lane_enable_n && high_lane_enable_n
            && cur.op == OP_BYTE_HIGH;
    endproperty
    a_aux_select: assert property (p_aux_select)
        else $error("aux select with wrong operation");

    property p_ata_word;
        @(posedge clk) disable iff (!rstn)
        (!task_file_select_n && cur.op == OP_WORD && cur.write)
            |-> card_data_lines_oe == 2'b11;
    endproperty
    a_ata_word: assert property (p_ata_word)
        else $error("ATA data transfer not a full word");

    property p_high_odd;
        @(posedge clk) disable iff (!rstn)
        (!high_lane_enable_n && low_lane_enable_n && cur.write)
            |-> card_data_lines_oe == 2'b10
            && card_data_lines_out[7:0] == 8'h00;
    endproperty
    a_high_odd: assert property (p_high_odd)
        else $error("high-lane byte not on high lanes");

    property p_low_byte;
        @(posedge clk) disable iff (!rstn)
        (!low_lane_enable_n && high_lane_enable_n && cur.write)
            |-> card_data_lines_oe == 2'b01
            && card_address[BYTE_ADDR_BIT] == cur.addr[BYTE_ADDR_BIT];
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low-lane byte misplaced");

    property p_read_release;
        @(posedge clk) disable iff (!rstn)
        (state == ST_ACTIVE && !cur.write) |-> card_data_lines_oe == 2'b00;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("host drives data lines during a read");

    property p_role_pin;
        @(posedge clk) disable iff (!rstn)
        ($past(cfg.mode) != MODE_ATA) |-> drive_role_select_oe;
    endproperty
    a_role_pin: assert property (p_role_pin)
        else $error("role pin floating outside ATA mode");

    property p_role_master;
        @(posedge clk) disable iff (!rstn)
        ($past(cfg.mode) == MODE_ATA) |->
            drive_role_select_oe == $past(cfg.master)
            && !drive_role_select_out;
    endproperty
    a_role_master: assert property (p_role_master)
        else $error("role pin does not follow master setting");

    property p_access_len;
        @(posedge clk) disable iff (!rstn)
        $rose(state == ST_ACTIVE) |-> (state == ST_ACTIVE) [*8]
            ##1 (state == ST_ACTIVE) [*2] ##1 rsp_valid;
    endproperty
    a_access_len: assert property (p_access_len)
        else $error("access length wrong");

endmodule : card_host_port

// *** card_model.sv ***
// Behavioural card: lane steering, register selects, role pin
module card_model
    import card_host_pkg::*;
(
    // Clock, mode and answer latency
    input  wire logic        clk,
    input  wire logic        ata,
    input  wire logic [3:0]  lat,
    // Selects from the host
    input  wire logic        low_n,
    input  wire logic        high_n,
    input  wire logic        tf_n,
    input  wire logic        aux_n,
    input  wire logic        dack_n,
    input  wire logic [10:0] addr,
    // Data lines and role pin
    input  wire logic [1:0]  hoe,
    input  wire logic [15:0] hdata,
    input  wire logic        role_out,
    input  wire logic        role_oe,
    output logic [15:0]      cdata,
    output logic [1:0]       coe,
    output logic             master
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [8];
    logic [7:0]  tf [8];
    logic [15:0] dw;
    logic [7:0]  aux;
    logic [7:0]  lo;
    logic [3:0]  age;
    logic [2:0]  w;
    logic        sel;
    logic        wide;

    assign w    = addr[3:1];
    assign wide = ata && (!dack_n || addr[2:0] == 3'h0);
    assign sel  = ata ? !(tf_n && aux_n && dack_n) : !(low_n && high_n);
    // Pull-up wins once the host lets go of the pin
    assign master = !(role_oe ? role_out : 1'b1);
    assign lo = ata ? (tf_n ? aux : tf[addr[2:0]])
              : (addr[0] && high_n ? mem[w][15:8] : mem[w][7:0]);
    assign cdata = wide ? dw : {mem[w][15:8], lo};

    // Slow answers leave the lines floating for lat cycles
    always_comb begin
        if (!sel || hoe != 2'h0 || age < lat) coe = 2'h0;
        else if (ata) coe = wide ? 2'h3 : 2'h1;
        else coe = {!high_n, !low_n};
    end

    always @(posedge clk) begin
        age <= sel ? (age == 4'hF ? age : age + 4'h1) : 4'h0;
        if (sel && hoe != 2'h0) begin
            if (wide) dw <= hdata;
            else if (ata && !tf_n) tf[addr[2:0]] <= hdata[7:0];
            else if (ata) aux <= hdata[7:0];
            else if (!low_n && !high_n) mem[w] <= hdata;
            else if (!low_n && !addr[0]) mem[w][7:0] <= hdata[7:0];
            else if (!low_n) mem[w][15:8] <= hdata[7:0];
            else mem[w][15:8] <= hdata[15:8];
        end
    end
endmodule : card_model

// *** card_select_byte_lane_decode_bench.sv ***
// Self-checking bench for the card select and byte-lane host port
module card_select_byte_lane_decode_bench import card_host_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, req_valid, req_ready, wr_valid, wr_ready;
    logic        rsp_valid, ln, hn, tn, an, dn, rout, roe, master;
    logic [1:0]  hoe, coe;
    logic [3:0]  lat;
    logic [10:0] caddr;
    logic [15:0] wr_data, hout, cdata, bus, rd;
    logic [15:0] last = 16'h0000;
    cfg_t        cfg;
    req_t        req;
    rsp_t        rsp;
    pins_t       p;
    int          error_cnt = 0;
    int          num_checks = 0;

    // No pull-ups on the data lines: a free lane shows noise
    assign bus[7:0]  = hoe[0] ? hout[7:0] : coe[0] ? cdata[7:0] : ~last[7:0];
    assign bus[15:8] = hoe[1] ? hout[15:8] : coe[1] ? cdata[15:8] : ~last[15:8];
    always @(posedge clk) last <= bus;

    card_host_port u_card_host_port (.clk, .rstn, .cfg, .req_valid, .req,
        .req_ready, .wr_valid, .wr_data, .wr_ready, .rsp_valid, .rsp,
        .low_lane_enable_n(ln), .high_lane_enable_n(hn),
        .task_file_select_n(tn), .aux_register_select_n(an),
        .dma_acknowledge_n(dn), .card_address(caddr),
        .drive_role_select_out(rout), .drive_role_select_oe(roe),
        .card_data_lines_out(hout), .card_data_lines_oe(hoe),
        .card_data_lines_in(bus));
    card_model u_card_model (.clk, .ata(cfg.mode == MODE_ATA), .lat,
        .low_n(ln), .high_n(hn), .tf_n(tn), .aux_n(an), .dack_n(dn),
        .addr(caddr), .hoe, .hdata(bus), .role_out(rout), .role_oe(roe),
        .cdata, .coe, .master);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(logic ok, string m);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic give_up();
        chk(1'b0, "timeout");
        tally_and_finish();
    endtask : give_up

    task automatic push(logic [15:0] d);
        int n;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wr_ready) break;
        end
        if (n == 50) give_up();
        wr_valid <= 1'b0;
    endtask : push

    // Snapshot of the pins is taken mid-access, while they stand
    task automatic acc(op_t op, logic w, logic up, logic [10:0] a);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{op, w, up, a};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (req_ready) break;
        end
        if (n == 50) give_up();
        req_valid <= 1'b0;
        repeat (5) @(posedge clk);
        p = '{ln, hn, tn, an, dn, caddr, hoe, hout};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rsp_valid) break;
        end
        if (n == 20) give_up();
        rd = rsp.data;
    endtask : acc

    task automatic wacc(op_t op, logic up, logic [10:0] a, logic [15:0] d);
        push(d);
        acc(op, 1'b1, up, a);
    endtask : wacc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_mem();
        wacc(OP_WORD, 1'b1, 11'h004, 16'hB4C3);
        chk(p.low_n===0 && p.high_n===0 && p.oe===2'h3, "word sel");
        chk(roe===1 && rout===1, "role follows upper address");
        acc(OP_BYTE_LOW, 1'b0, 1'b0, 11'h004);
        chk(p.high_n===1 && rd[7:0]===8'hC3, "even byte");
        chk(roe===1 && rout===0, "role low");
        acc(OP_BYTE_LOW, 1'b0, 1'b0, 11'h005);
        chk(p.addr[0]===1 && rd[7:0]===8'hB4, "odd byte low lanes");
        acc(OP_BYTE_HIGH, 1'b0, 1'b0, 11'h004);
        chk(p.low_n===1 && p.high_n===0 && rd[7:0]===8'hB4, "odd hi");
        wacc(OP_BYTE_HIGH, 1'b0, 11'h004, 16'h00D9);
        chk(p.oe===2'h2 && p.dout===16'hD900, "odd wr hi");
        wacc(OP_BYTE_LOW, 1'b0, 11'h005, 16'h007E);
        chk(p.oe===2'h1 && p.dout[7:0]===8'h7E, "odd byte write");
        lat = 4'h0;
        acc(OP_WORD, 1'b0, 1'b0, 11'h004);
        chk(rd===16'h7EC3, "lane order");
        lat = 4'h5;
    endtask : t_mem

    task automatic t_ata();
        @(posedge clk);
        cfg <= '{MODE_ATA, 1'b1};
        repeat (2) @(posedge clk);
        chk(roe===1 && rout===0 && master===1, "master");
        cfg <= '{MODE_ATA, 1'b0};
        repeat (2) @(posedge clk);
        chk(roe===0 && master===0, "slave");
        wacc(OP_BYTE_LOW, 1'b0, 11'h7FD, 16'h005C);
        chk(p.tf_n===0 && p.aux_n===1 && p.addr===11'h005, "tf");
        chk(p.low_n===1 && p.oe===2'h1, "tf byte lane");
        acc(OP_BYTE_LOW, 1'b0, 1'b0, 11'h005);
        chk(rd[7:0]===8'h5C, "tf read");
        wacc(OP_BYTE_HIGH, 1'b0, 11'h006, 16'h003A);
        chk(p.aux_n===0 && p.tf_n===1, "aux select");
        acc(OP_BYTE_HIGH, 1'b0, 1'b0, 11'h006);
        chk(rd[7:0]===8'h3A, "aux read");
        wacc(OP_WORD, 1'b0, 11'h000, 16'hE1F2);
        chk(p.tf_n===0 && p.oe===2'h3, "data word");
        acc(OP_DMA_WORD, 1'b0, 1'b0, 11'h000);
        chk(p.dack_n===0 && p.tf_n===1 && p.aux_n===1, "dma sel");
        chk(rd===16'hE1F2 && rsp.op===OP_DMA_WORD, "dma read");
        wacc(OP_DMA_WORD, 1'b0, 11'h000, 16'h6B7A);
        chk(p.tf_n===1 && p.aux_n===1 && p.oe===2'h3, "dma write");
        acc(OP_WORD, 1'b0, 1'b0, 11'h000);
        chk(rd===16'h6B7A, "word read");
    endtask : t_ata

    task automatic t_fill();
        @(posedge clk);
        cfg <= '{MODE_IO, 1'b0};
        for (int i = 0; i < 8; i++) push(16'h1000 | 16'(i));
        @(posedge clk);
        chk(wr_ready===0, "fifo full");
        for (int i = 0; i < 8; i++) begin
            acc(OP_WORD, 1'b1, 1'b0, 11'(2 * i));
            chk(p.dout===(16'h1000 | 16'(i)), "fifo order");
        end
        chk(wr_ready===1, "fifo drained");
    endtask : t_fill

    // Reset with a word still buffered
    task automatic t_reset();
        push(16'h0F0F);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        chk(req_ready===0 && rsp_valid===0 && wr_ready===1, "rst");
        chk(ln===1 && hn===1 && hoe===2'h0 && roe===1, "rst pins");
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(req_ready===1 && wr_ready===1, "ready after reset");
    endtask : t_reset

    initial begin
        rstn      = 1'b0;
        req_valid = 1'b0;
        wr_valid  = 1'b0;
        req       = REQ_RESET;
        wr_data   = 16'h0000;
        cfg       = '{MODE_MEMORY, 1'b0};
        lat       = 4'h5;
        repeat (3) @(posedge clk);
        chk(ln===1 && hn===1 && tn===1 && hoe===2'h0 && roe===1, "rst");
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_mem();
        t_ata();
        t_fill();
        t_reset();
        tally_and_finish();
    end
endmodule : card_select_byte_lane_decode_bench
